//--- hdl/aoc_pkg.sv
// Purpose: Shared constants for the converter output-coding and mode block
// Assumes: 12-bit sample words, one sampling clock, APB register access
// Notes: Register offsets are byte addresses of aligned 32-bit words
package aoc_pkg;

  // Word geometry and pipeline depth
  localparam int CODE_W = 12;
  localparam int PIPE_LAT = 5;

  // Characteristic codes in straight offset binary
  localparam logic [11:0] CODE_NEG_FS = 12'h000;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [11:0] CODE_POS_FS = 12'hFFF;
  localparam int MSB_POS = 11;

  // Full-scale range selections reported by the mode logic
  typedef enum logic [1:0] {
    AOC_RANGE_2V0 = 2'b00,
    AOC_RANGE_1V5 = 2'b01,
    AOC_RANGE_1V0 = 2'b10,
    AOC_RANGE_EXT = 2'b11
  } aoc_range_t;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_OVR_COUNT = 8'h10;

  // Control fields
  localparam int CTRL_SW_CODING_EN = 0;
  localparam int CTRL_SW_CODING = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status fields
  localparam int STAT_CODING = 0;
  localparam int STAT_EXT_REF = 1;
  localparam int STAT_RANGE_LO = 2;
  localparam int STAT_PIPE_FULL = 4;
  localparam int STAT_POWER_DOWN = 5;

  // Interrupt event bits, shared by status and mask
  localparam int IRQ_W = 3;
  localparam int IRQ_OVR = 0;
  localparam int IRQ_EXT_REF = 1;
  localparam int IRQ_REFILLED = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // Over-range counter width
  localparam int OVR_CNT_W = 16;

  // Sampling clock floor kept by the clock source (1 MHz); reference clock period in ns
  localparam int MIN_SAMPLE_KHZ = 1000;
  localparam int REF_CLK_NS = 10;

endpackage : aoc_pkg

//--- hdl/aoc_coder.sv
// Purpose: Clamp a raw quantizer result and code it as offset binary or two's complement
// Assumes: Raw code is straight offset binary; over flags mark beyond-range inputs
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module aoc_coder
  import aoc_pkg::*;
(
  // Raw sample
  input wire logic [CODE_W-1:0] raw_code,
  input wire logic over_hi,
  input wire logic over_lo,
  // Format choice
  input wire logic twos_sel,
  // Coded result
  output logic [CODE_W-1:0] word,
  output logic over_range_flag
);

  // Clamped offset-binary value before format conversion
  logic [CODE_W-1:0] offset_binary_code;

  // Beyond range saturates to the end codes; low side wins if both are set
  always_comb begin
    if (over_lo) begin
      offset_binary_code = CODE_NEG_FS;
    end else if (over_hi) begin
      offset_binary_code = CODE_POS_FS;
    end else begin
      offset_binary_code = raw_code;
    end
  end

  // Two's complement differs only in the top bit
  always_comb begin
    word = offset_binary_code;
    word[MSB_POS] = offset_binary_code[MSB_POS] ^ twos_sel;
  end

  // Flag raised for either side of the range
  assign over_range_flag = over_hi | over_lo;

endmodule // aoc_coder
`default_nettype wire

//--- hdl/aoc_top.sv
// Purpose: Output coding, reference mode and pipeline of a 12-bit sampling converter
// Assumes: All inputs synchronous to REF_CLK; sample presented every enabled cycle
// Notes: APB slave with zero wait states; one level interrupt output
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module aoc_top
  import aoc_pkg::*;
#(
  parameter int LAT = PIPE_LAT
)
(
  // Clock, reset and clock enable
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // Quantizer result for the current sample
  input wire logic [CODE_W-1:0] SAMPLE_CODE,
  input wire logic SAMPLE_OVER_HI,
  input wire logic SAMPLE_OVER_LO,
  // Straps and mode pins
  input wire logic CODING_SELECT,
  input wire logic REF_LEVEL_HIGH,
  input wire logic RANGE_STRAP_A,
  input wire logic RANGE_STRAP_B,
  input wire logic POWER_DOWN_REQUEST,
  input wire logic OUTPUT_ENABLE_N,
  // Sample outputs
  output logic [CODE_W-1:0] DATA_OUT,
  output logic DATA_OUT_EN_N,
  output logic OVER_RANGE_FLAG,
  output logic DATA_VALID,
  // Reference mode outputs
  output logic EXT_REF_MODE,
  output logic [1:0] RANGE_SEL,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt
  output logic IRQ
);

  // Pick the range from the straps unless the external reference is in use
  function automatic aoc_range_t range_of(input logic ext, input logic a, input logic b);
    aoc_range_t r;
    r = AOC_RANGE_2V0;
    if (ext) begin
      r = AOC_RANGE_EXT;
    end else if (!a && b) begin
      r = AOC_RANGE_1V5;
    end else if (a && !b) begin
      r = AOC_RANGE_1V0;
    end
    return r;
  endfunction

  // Pipeline stages: word, flag and valid travel together
  logic [CODE_W-1:0] pipe_word_r [LAT];
  logic [LAT-1:0] pipe_ovr_r;
  logic [LAT-1:0] pipe_vld_r;
  // Control and interrupt registers
  logic [1:0] ctrl_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [OVR_CNT_W-1:0] ovr_cnt_r;
  // Mode state
  logic ext_ref_r;
  aoc_range_t range_r;
  logic ext_ref_nxt;
  // Coder results for the incoming sample
  logic twos_sel;
  logic [CODE_W-1:0] coded_word;
  logic coded_ovr;
  // Events and bus decode
  logic [IRQ_W-1:0] evt;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic vld_last_r;

  // Software may override the coding strap; after reset the strap rules
  assign twos_sel = ctrl_r[CTRL_SW_CODING_EN] ? ctrl_r[CTRL_SW_CODING] : CODING_SELECT;

  // Coder for the sample entering the pipeline
  aoc_coder u_coder (
    .raw_code(SAMPLE_CODE),
    .over_hi(SAMPLE_OVER_HI),
    .over_lo(SAMPLE_OVER_LO),
    .twos_sel(twos_sel),
    .word(coded_word),
    .over_range_flag(coded_ovr)
  );

  // Pipeline shift, one stage per enabled edge; power-down on an enabled edge drops everything
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || (CLK_EN && POWER_DOWN_REQUEST)) begin
      pipe_vld_r <= '0;
      pipe_ovr_r <= '0;
      for (int i = 0; i < LAT; i++) begin
        pipe_word_r[i] <= CODE_NEG_FS;
      end
    end else if (CLK_EN) begin
      pipe_word_r[0] <= coded_word;
      pipe_ovr_r[0] <= coded_ovr;
      pipe_vld_r[0] <= 1'b1;
      for (int i = 1; i < LAT; i++) begin
        pipe_word_r[i] <= pipe_word_r[i-1];
        pipe_ovr_r[i] <= pipe_ovr_r[i-1];
        pipe_vld_r[i] <= pipe_vld_r[i-1];
      end
    end
  end

  // Word and flag leave the same last stage, so they change on one edge
  assign DATA_OUT = pipe_word_r[LAT-1];
  assign OVER_RANGE_FLAG = pipe_ovr_r[LAT-1];
  assign DATA_VALID = pipe_vld_r[LAT-1];
  // Output drivers follow the enable pin directly; enable is active low
  assign DATA_OUT_EN_N = OUTPUT_ENABLE_N;

  // Reference mode tracks the level comparator; range held alongside it
  assign ext_ref_nxt = REF_LEVEL_HIGH;
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ext_ref_r <= 1'b0;
      range_r <= AOC_RANGE_2V0;
    end else if (CLK_EN) begin
      ext_ref_r <= ext_ref_nxt;
      range_r <= range_of(ext_ref_nxt, RANGE_STRAP_A, RANGE_STRAP_B);
    end
  end
  assign EXT_REF_MODE = ext_ref_r;
  assign RANGE_SEL = range_r;

  // Refill detection needs the previous output valid
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      vld_last_r <= 1'b0;
    end else if (CLK_EN) begin
      vld_last_r <= pipe_vld_r[LAT-1];
    end
  end

  // Events: over-range word out, entry to external mode, pipeline refilled
  always_comb begin
    evt = '0;
    evt[IRQ_OVR] = pipe_vld_r[LAT-1] && pipe_ovr_r[LAT-1];
    evt[IRQ_EXT_REF] = ext_ref_nxt && !ext_ref_r;
    evt[IRQ_REFILLED] = pipe_vld_r[LAT-1] && !vld_last_r;
  end

  // APB decode; every access completes with no wait state
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && !PWRITE;
  always_comb begin
    unique case (PADDR)
      OFS_CTRL, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_OVR_COUNT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // Control register; the bus is not gated by the clock enable
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ctrl_r <= CTRL_RESET;
    end else if (apb_wr && PADDR == OFS_CTRL) begin
      ctrl_r <= PWDATA[1:0];
    end
  end

  // Mask register
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      irq_mask_r <= IRQ_RESET;
    end else if (apb_wr && PADDR == OFS_IRQ_MASK) begin
      irq_mask_r <= PWDATA[IRQ_W-1:0];
    end
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      irq_stat_r <= IRQ_RESET;
    end else begin
      if (apb_wr && PADDR == OFS_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~PWDATA[IRQ_W-1:0]) | (CLK_EN ? evt : IRQ_RESET);
      end else if (CLK_EN) begin
        irq_stat_r <= irq_stat_r | evt;
      end
    end
  end
  assign IRQ = |(irq_stat_r & irq_mask_r);

  // Over-range word counter, saturating so it never wraps to a small value
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ovr_cnt_r <= '0;
    end else if (apb_wr && PADDR == OFS_OVR_COUNT) begin
      ovr_cnt_r <= '0;
    end else if (CLK_EN && evt[IRQ_OVR] && !(&ovr_cnt_r)) begin
      ovr_cnt_r <= ovr_cnt_r + 1'b1;
    end
  end

  // Read data registered in the setup cycle, stable through the access phase
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PRDATA <= '0;
    end else if (apb_rd && !PENABLE) begin
      PRDATA <= '0;
      unique case (PADDR)
        OFS_CTRL: PRDATA[1:0] <= ctrl_r;
        OFS_STATUS: begin
          PRDATA[STAT_CODING] <= twos_sel;
          PRDATA[STAT_EXT_REF] <= ext_ref_r;
          PRDATA[STAT_RANGE_LO +: 2] <= range_r;
          PRDATA[STAT_PIPE_FULL] <= pipe_vld_r[LAT-1];
          PRDATA[STAT_POWER_DOWN] <= POWER_DOWN_REQUEST;
        end
        OFS_IRQ_STAT: PRDATA[IRQ_W-1:0] <= irq_stat_r;
        OFS_IRQ_MASK: PRDATA[IRQ_W-1:0] <= irq_mask_r;
        OFS_OVR_COUNT: PRDATA[OVR_CNT_W-1:0] <= ovr_cnt_r;
        default: PRDATA <= '0;
      endcase
    end
  end

  // Checks; latency, flush and mode checks require the clock enable high, the pair check covers it low
  property p_latency_word;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (CLK_EN && !POWER_DOWN_REQUEST) ##1 (CLK_EN && !POWER_DOWN_REQUEST)[*4]
      |=> DATA_VALID && DATA_OUT == $past(coded_word, 5);
  endproperty
  chk_word_latency: assert property (p_latency_word) else $error("word latency wrong");
  chk_ovr_aligned: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (CLK_EN && !POWER_DOWN_REQUEST && (SAMPLE_OVER_HI || SAMPLE_OVER_LO))
    ##1 (CLK_EN && !POWER_DOWN_REQUEST)[*4] |=> OVER_RANGE_FLAG)
    else $error("over-range flag not aligned");
  chk_twos_msb: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    twos_sel |-> coded_word[MSB_POS] != (SAMPLE_OVER_HI && !SAMPLE_OVER_LO ? 1'b1
      : SAMPLE_OVER_LO ? 1'b0 : SAMPLE_CODE[MSB_POS]))
    else $error("two's complement top bit wrong");
  chk_sob_pass: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!twos_sel && !SAMPLE_OVER_HI && !SAMPLE_OVER_LO) |-> coded_word == SAMPLE_CODE)
    else $error("offset binary word altered");
  chk_neg_clamp: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    SAMPLE_OVER_LO |-> coded_word == (twos_sel ? CODE_MID : CODE_NEG_FS) && coded_ovr)
    else $error("negative full scale code wrong");
  chk_pos_clamp: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (SAMPLE_OVER_HI && !SAMPLE_OVER_LO) |-> coded_word == (twos_sel ? ~CODE_MID : CODE_POS_FS))
    else $error("positive full scale code wrong");
  chk_mid_code: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (SAMPLE_CODE == CODE_MID && !SAMPLE_OVER_HI && !SAMPLE_OVER_LO && twos_sel)
    |-> coded_word == CODE_NEG_FS)
    else $error("midpoint code wrong");
  chk_ext_straps: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (CLK_EN && REF_LEVEL_HIGH) |=> EXT_REF_MODE && RANGE_SEL == AOC_RANGE_EXT)
    else $error("straps not ignored in external mode");
  chk_pd_flush: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (CLK_EN && POWER_DOWN_REQUEST) ##1 (CLK_EN && !POWER_DOWN_REQUEST)[*4] |-> !DATA_VALID)
    else $error("pipeline refilled too early");
  chk_oe_follow: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    DATA_OUT_EN_N == OUTPUT_ENABLE_N && $stable(DATA_OUT_EN_N) == $stable(OUTPUT_ENABLE_N))
    else $error("output enable not followed");
  chk_pair_update: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !CLK_EN |=> $stable(DATA_OUT) && $stable(OVER_RANGE_FLAG))
    else $error("word or flag moved while frozen");

  // Main scenarios
  cov_twos_out: cover property (@(posedge REF_CLK) DATA_VALID && twos_sel);
  cov_ovr_out: cover property (@(posedge REF_CLK) DATA_VALID && OVER_RANGE_FLAG);
  cov_ext_ref: cover property (@(posedge REF_CLK) $rose(EXT_REF_MODE));
  cov_refill: cover property (@(posedge REF_CLK) $rose(DATA_VALID) && irq_stat_r[IRQ_REFILLED]);

endmodule // aoc_top
`default_nettype wire

//--- verification/aoc_sink.sv
// Purpose: Receiver model that captures coded sample words and the over-range flag
// Assumes: Captures on rising clock while the outputs are driven and valid
// Notes: An undriven bus shows the inverse of its last level, never a held value
`timescale 1ns/1ps
`default_nettype none
module aoc_sink
  import aoc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Converter outputs
  input wire logic [CODE_W-1:0] word,
  input wire logic flag,
  input wire logic valid,
  input wire logic en_n,
  // Captured pair
  output logic [CODE_W-1:0] cap_word_r,
  output logic cap_flag_r,
  output logic cap_new_r
);
  logic [CODE_W-1:0] last_r; // Last bus level seen
  logic [CODE_W-1:0] bus_w; // Level at the receiver pins
  // Floating bus must not look like stale data
  assign bus_w = en_n ? ~last_r : word;
  // Word and flag taken as one pair on one edge
  always_ff @(posedge clk) begin
    last_r <= bus_w;
    cap_new_r <= valid & ~en_n;
    if (valid & ~en_n) begin
      cap_word_r <= bus_w;
      cap_flag_r <= flag;
    end
  end
endmodule // aoc_sink
`default_nettype wire

//--- verification/test_adc_output_coding_and_mode.sv
// Purpose: Self-checking bench for output coding, reference mode and pipeline
// Assumes: 100 MHz clock; the reference model sees only the bench inputs
// Notes: Seeded random traffic with corner codes, then APB and interrupt steps
`timescale 1ns/1ps
`default_nettype none
module test_adc_output_coding_and_mode;
  import aoc_pkg::*;
  localparam int LAT = PIPE_LAT;
  localparam logic [11:0] CORN [8] = '{12'h000, 12'h800, 12'hFFF, 12'h7FF, 12'hC00, 12'h400, 12'h001, 12'hFFE};
  logic clk, rst, cen, hi, lo, sel, refh, sa, sb, pd, oe_n, psel, pen, pwr, err, lc, lf, ee;
  logic over_range_flag, en_n, vld, ext, pready, pslverr, irq, cap_f, cap_n;
  logic [11:0] code, dout, cap_w, lw;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [1:0] rsel, er;
  logic [11:0] ew [LAT]; // Expected word per stage
  logic ef [LAT]; // Expected flag per stage
  logic ev [LAT]; // Expected valid per stage
  int err_total, checks_done, seed;

  // Even duty at 100 MHz, far above the sampling floor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  aoc_top #(.LAT(LAT)) aoc_top_inst (.REF_CLK(clk), .SYS_RST(rst), .CLK_EN(cen), .SAMPLE_CODE(code),
    .SAMPLE_OVER_HI(hi), .SAMPLE_OVER_LO(lo), .CODING_SELECT(sel), .REF_LEVEL_HIGH(refh),
    .RANGE_STRAP_A(sa), .RANGE_STRAP_B(sb), .POWER_DOWN_REQUEST(pd), .OUTPUT_ENABLE_N(oe_n),
    .DATA_OUT(dout), .DATA_OUT_EN_N(en_n), .OVER_RANGE_FLAG(over_range_flag), .DATA_VALID(vld), .EXT_REF_MODE(ext),
    .RANGE_SEL(rsel), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));

  aoc_sink aoc_sink_inst (.clk(clk), .word(dout), .flag(over_range_flag), .valid(vld), .en_n(en_n),
    .cap_word_r(cap_w), .cap_flag_r(cap_f), .cap_new_r(cap_n));

  // Clamp, then flip the top bit for two's complement
  function automatic logic [11:0] f_code(logic [11:0] raw, logic h, logic l, logic t);
    logic [11:0] w;
    w = l ? CODE_NEG_FS : (h ? CODE_POS_FS : raw);
    w[MSB_POS] = w[MSB_POS] ^ t;
    return w;
  endfunction

  // External mode overrides the straps; both straps high means widest range
  function automatic logic [1:0] f_rng(logic x, logic a, logic b);
    if (x) return AOC_RANGE_EXT;
    return (a ^ b) ? {a, b} : AOC_RANGE_2V0;
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task report_and_stop;
    $display("Checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      report_and_stop;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask

  // Reference pipeline and mode, moved only on enabled edges
  always @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < LAT; k++) begin
        ew[k] <= 12'h000; ef[k] <= 1'b0; ev[k] <= 1'b0;
      end
      ee <= 1'b0; er <= 2'h0;
    end else if (cen) begin
      ee <= refh;
      er <= f_rng(refh, sa, sb);
      for (int k = LAT - 1; k > 0; k--) begin
        ew[k] <= pd ? 12'h000 : ew[k-1]; ef[k] <= ~pd & ef[k-1]; ev[k] <= ~pd & ev[k-1];
      end
      ew[0] <= pd ? 12'h000 : f_code(code, hi, lo, sel);
      ef[0] <= ~pd & (hi | lo);
      ev[0] <= ~pd;
    end
  end

  // Outputs compared mid-cycle, after every edge has settled
  always @(negedge clk) begin
    if (!rst) begin
      chk("data", dout, ew[LAT-1]);
      chk("flag", over_range_flag, ef[LAT-1]);
      chk("valid", vld, ev[LAT-1]);
      chk("enable", en_n, oe_n);
      chk("ext", ext, ee);
      chk("range", rsel, er);
      if (lc) chk("capture", {cap_n, cap_f, cap_w}, {1'b1, lf, lw});
      lc = vld & ~en_n;
      lw = dout;
      lf = over_range_flag;
    end
  end

  initial begin
    seed = 29; err_total = 0; checks_done = 0; lc = 1'b0; rst = 1'b1; cen = 1'b1; code = 12'h000;
    {hi, lo, sel, refh, sa, sb, pd, oe_n, psel, pen, pwr} = 11'h000; paddr = 8'h00; pwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped address
    apb(1'b0, OFS_CTRL, 32'h0); chk("ctrl", rd, 64'h0);
    apb(1'b0, OFS_IRQ_MASK, 32'h0); chk("mask", rd, 64'h0);
    apb(1'b0, 8'h20, 32'h0); chk("hole", {err, rd}, 64'h100000000);
    // Random traffic with corner codes, stalls, power-down and mode flips
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk);
      r = $random(seed);
      code <= r[3] ? r[31:20] : CORN[r[2:0]];
      hi <= &r[6:4]; lo <= &r[9:7]; sel <= r[10]; cen <= |r[13:11]; pd <= &r[17:14];
      refh <= (&r[19:18]) ? ~refh : refh; sa <= r[20]; sb <= r[21]; oe_n <= &r[23:22];
      @(negedge clk) chk("irq masked", irq, 64'h0);
    end
    // Quiet inputs, then clear every pending event
    @(posedge clk);
    {cen, pd, hi, lo, oe_n} <= 5'h10; code <= 12'h123;
    repeat (LAT + 1) @(posedge clk);
    apb(1'b1, OFS_IRQ_STAT, 32'h7);
    apb(1'b0, OFS_IRQ_STAT, 32'h0); chk("stat clear", rd, 64'h0);
    apb(1'b1, OFS_OVR_COUNT, 32'h0);
    // One over-range sample: sticky bit, mask, then write-one clear
    @(posedge clk) hi <= 1'b1;
    @(posedge clk) hi <= 1'b0;
    repeat (LAT + 1) @(negedge clk);
    chk("irq held", irq, 64'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0); chk("stat ovr", rd[IRQ_OVR], 64'h1);
    apb(1'b0, OFS_OVR_COUNT, 32'h0); chk("ovr count", rd, 64'h1);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    @(negedge clk) chk("irq on", irq, 64'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    @(negedge clk) chk("irq off", irq, 64'h0);
    report_and_stop;
  end
endmodule // test_adc_output_coding_and_mode
`default_nettype wire
